// File: rtl/sdmb_core.sv
// sdram bank, mode and burst core with latency pipeline and write buffer
//
// How it works
// [R01] pins sampled only on rising clock edge
// [R02] new column accepted any cycle, even mid-burst
// [R03] bank is 4096 rows of 256 columns of 16 bits
// [R04] active takes bank and row; read/write take column
// [R05] controller opens a row before access
// [R06] precharging one bank leaves other bursts running
// [R07] auto precharge closes the row at burst end
// [R08] controller idles 100us after power-up
// [R09] controller then precharges all banks
// [R10] controller does two auto refreshes before mode load
// [R11] controller loads mode before operational commands
// [R12] mode changes only on load mode register
// [R13] mode fields: length, order, latency, op mode, write mode
// [R14] mode loaded only with banks idle, then a wait
// [R15] burst length bounds columns per access
// [R16] lengths 1, 2, 4, 8 in both orders
// [R17] full page sequential only; terminate cuts it
// [R18] bursts wrap inside an aligned block
// [R19] full page wraps within the open row
// [R20] reserved length codes never programmed
// [R21] latency two or three: drive n+m-1, valid n+m
// [R22] order bit picks sequential or interleaved
// [R23] write mode bit one makes writes single beat
// [R24] commands decode from select, ras, cas, we levels
`timescale 1ns/100ps
module sdmb_core #(
   parameter int WBUF_DEPTH = sdmb_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   // command and address pins
   input  wire sdmb_pkg::sdmb_pins_t        pins,
   // data pins, split into in, out and enable
   input  wire logic [sdmb_pkg::DATA_W-1:0] dq_in,
   output logic [sdmb_pkg::DATA_W-1:0]      dq_out,
   output logic                             dq_oe_n,
   // status
   output logic                             wr_buf_ready,
   output logic [sdmb_pkg::NUM_BANKS-1:0]   bank_open
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [sdmb_pkg::MODE_W-1:0]                         mode;
      logic [sdmb_pkg::NUM_BANKS-1:0]                      open;
      logic [sdmb_pkg::NUM_BANKS-1:0][sdmb_pkg::ROW_W-1:0] row;
      sdmb_pkg::sdmb_burst_t                               burst;
      logic [sdmb_pkg::BANK_W-1:0]                         bank;
      logic [sdmb_pkg::COL_W-1:0]                          start;
      logic [sdmb_pkg::LEN_W-1:0]                          idx;
      logic [sdmb_pkg::LEN_W-1:0]                          len;
      logic                                                il;
      logic                                                ap;
      logic                                                rv0;
      logic                                                rv1;
      logic [sdmb_pkg::DATA_W-1:0]                         hold;
      logic [sdmb_pkg::DATA_W-1:0]                         dq_out;
      logic                                                dq_oe_n;
      logic                                                wbuf_rdy;
   } sdmb_core_st_t;

   sdmb_core_st_t s_q;
   sdmb_core_st_t s_d;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // column of beat k inside the block chosen by the length
   function automatic logic [sdmb_pkg::COL_W-1:0] beat_col(
      input logic [sdmb_pkg::COL_W-1:0] start,
      input logic [sdmb_pkg::COL_W-1:0] k,
      input logic [sdmb_pkg::LEN_W-1:0] len,
      input logic                       il
   );
      logic [sdmb_pkg::LEN_W-1:0] m9;
      logic [sdmb_pkg::COL_W-1:0] mask;
      logic [sdmb_pkg::COL_W-1:0] off;
      m9   = len - sdmb_pkg::LEN_1;
      mask = m9[sdmb_pkg::COL_W-1:0];
      off  = il ? (start ^ k) : (start + k);            // R22
      return (start & ~mask) | (off & mask);            // R18 R19
   endfunction

   function automatic logic [sdmb_pkg::LEN_W-1:0] code_len(
      input logic [2:0] code
   );
      logic [sdmb_pkg::LEN_W-1:0] l;
      case (code)
         sdmb_pkg::BL_CODE_1:    l = sdmb_pkg::LEN_1;
         sdmb_pkg::BL_CODE_2:    l = sdmb_pkg::LEN_2;
         sdmb_pkg::BL_CODE_4:    l = sdmb_pkg::LEN_4;
         sdmb_pkg::BL_CODE_8:    l = sdmb_pkg::LEN_8;
         sdmb_pkg::BL_CODE_FULL: l = sdmb_pkg::LEN_FULL;
         // reserved codes fall back to single beats
         default:                l = sdmb_pkg::LEN_1;
      endcase
      return l;
   endfunction

   // ------------------------------------------------------------------
   // datapath nets
   // ------------------------------------------------------------------
   sdmb_pkg::sdmb_cmd_t                 cmd;
   logic                                sel;
   logic [sdmb_pkg::BANK_W-1:0]         pin_bank;
   logic [2:0]                          burst_length_code;
   logic                                burst_order_bit;
   logic [2:0]                          read_latency_code;
   logic                                write_burst_mode_bit;
   logic [sdmb_pkg::LEN_W-1:0]          new_len;
   logic                                new_il;
   logic                                rd_acc;
   logic                                wr_acc;
   logic [sdmb_pkg::BANK_W-1:0]         acc_bank;
   logic [sdmb_pkg::COL_W-1:0]          acc_col;
   logic [sdmb_pkg::MEM_AW-1:0]         acc_addr;
   logic [sdmb_pkg::DATA_W-1:0]         mem_rdata;
   sdmb_pkg::sdmb_wr_ent_t              wr_in;
   sdmb_pkg::sdmb_wr_ent_t              wr_out;
   logic                                wbuf_in_ready;
   logic                                wbuf_out_valid;
   logic                                full_page;

   assign pin_bank             = {pins.bank_select_msb, pins.bank_select_lsb};
   assign burst_length_code    = s_q.mode[sdmb_pkg::BL_LSB +: 3];     // R13
   assign burst_order_bit      = s_q.mode[sdmb_pkg::BT_BIT];
   assign read_latency_code    = s_q.mode[sdmb_pkg::CL_LSB +: 3];
   assign write_burst_mode_bit = s_q.mode[sdmb_pkg::WBM_BIT];
   assign full_page            = (s_q.len == sdmb_pkg::LEN_FULL);

   // ------------------------------------------------------------------
   // command decode and burst sequencing
   // ------------------------------------------------------------------
   always_comb begin
      s_d      = s_q;
      sel      = !pins.cs_n;                                          // R24
      cmd      = sdmb_pkg::sdmb_cmd_t'({pins.ras_n, pins.cas_n, pins.we_n});
      rd_acc   = 1'b0;
      wr_acc   = 1'b0;
      acc_bank = s_q.bank;
      acc_col  = beat_col(s_q.start, s_q.idx[sdmb_pkg::COL_W-1:0], s_q.len, s_q.il);
      new_len  = code_len(burst_length_code);                         // R15 R16
      // interleave is only legal on fixed lengths; full page stays linear
      new_il   = burst_order_bit && (new_len != sdmb_pkg::LEN_FULL);  // R17

      // continuing beats come from the column counter
      case (s_q.burst)
         sdmb_pkg::SDMB_RD,
         sdmb_pkg::SDMB_WR: begin
            rd_acc = (s_q.burst == sdmb_pkg::SDMB_RD);
            wr_acc = (s_q.burst == sdmb_pkg::SDMB_WR);
            s_d.idx = s_q.idx + sdmb_pkg::LEN_1;
            if (!full_page && (s_d.idx == s_q.len)) begin             // R15
               s_d.burst = sdmb_pkg::SDMB_IDLE;
               if (s_q.ap) begin
                  s_d.open[s_q.bank] = 1'b0;                          // R07
               end
            end
         end
         default: begin
         end
      endcase

      if (sel) begin                                                  // R01
         case (cmd)
            sdmb_pkg::SDMB_CMD_LMR: begin
               s_d.mode = pins.addr;                                  // R12
            end
            sdmb_pkg::SDMB_CMD_ACT: begin
               s_d.open[pin_bank] = 1'b1;                             // R04
               s_d.row[pin_bank]  = pins.addr;
            end
            sdmb_pkg::SDMB_CMD_PRE: begin
               // the selected bank, or every bank with address bit 10, closes while bursts keep running
               if (pins.addr[sdmb_pkg::AP_BIT]) begin
                  s_d.open = '0;
               end else begin
                  s_d.open[pin_bank] = 1'b0;                          // R06
               end
            end
            sdmb_pkg::SDMB_CMD_RD,
            sdmb_pkg::SDMB_CMD_WR: begin
               // a fresh column cuts any running burst short
               rd_acc    = (cmd == sdmb_pkg::SDMB_CMD_RD);            // R02
               wr_acc    = (cmd == sdmb_pkg::SDMB_CMD_WR);
               if (wr_acc && write_burst_mode_bit) begin
                  new_len = sdmb_pkg::LEN_1;                          // R23
               end
               acc_bank  = pin_bank;
               acc_col   = pins.addr[sdmb_pkg::COL_W-1:0];            // R04
               s_d.bank  = pin_bank;
               s_d.start = pins.addr[sdmb_pkg::COL_W-1:0];
               s_d.len   = new_len;
               s_d.il    = new_il;
               s_d.ap    = pins.addr[sdmb_pkg::AP_BIT];
               s_d.idx   = sdmb_pkg::LEN_1;
               if (new_len == sdmb_pkg::LEN_1) begin
                  s_d.burst = sdmb_pkg::SDMB_IDLE;
                  if (pins.addr[sdmb_pkg::AP_BIT]) begin
                     s_d.open[pin_bank] = 1'b0;                       // R07
                  end
               end else begin
                  s_d.burst = rd_acc ? sdmb_pkg::SDMB_RD : sdmb_pkg::SDMB_WR;
               end
            end
            sdmb_pkg::SDMB_CMD_BST: begin
               // the beat in the terminate cycle is dropped
               s_d.burst = sdmb_pkg::SDMB_IDLE;                       // R17
               rd_acc    = 1'b0;
               wr_acc    = 1'b0;
            end
            default: begin
            end
         endcase
      end

      // read latency pipeline; array data lands one edge after the access
      s_d.rv0  = rd_acc;
      s_d.rv1  = s_q.rv0;
      s_d.hold = mem_rdata;
      if (read_latency_code == sdmb_pkg::CL_CODE_3) begin
         s_d.dq_out  = s_q.hold;                                      // R21
         s_d.dq_oe_n = !s_q.rv1;
      end else begin
         s_d.dq_out  = mem_rdata;                                     // R21
         s_d.dq_oe_n = !s_q.rv0;
      end
      s_d.wbuf_rdy = wbuf_in_ready;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q         <= '0;
         s_q.mode    <= sdmb_pkg::MODE_RESET;
         s_q.burst   <= sdmb_pkg::SDMB_IDLE;
         s_q.dq_oe_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------------
   // write buffer and array
   // ------------------------------------------------------------------
   // reads own the array port; writes wait in the buffer, so a read of a
   // column written a few cycles earlier can see the old word
   assign acc_addr     = {acc_bank, s_q.row[acc_bank], acc_col};      // R03
   assign wr_in.addr   = acc_addr;
   assign wr_in.data   = dq_in;
   assign dq_out       = s_q.dq_out;
   assign dq_oe_n      = s_q.dq_oe_n;
   assign wr_buf_ready = s_q.wbuf_rdy;
   assign bank_open    = s_q.open;

   sdmb_fifo #(
      .WIDTH (sdmb_pkg::WR_ENT_W),
      .DEPTH (WBUF_DEPTH)
   ) u_wbuf (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (wr_acc && !pins.dqm),
      .in_ready  (wbuf_in_ready),
      .in_data   (wr_in),
      .out_valid (wbuf_out_valid),
      .out_ready (!rd_acc),
      .out_data  (wr_out)
   );

   sdmb_mem #(
      .AW (sdmb_pkg::MEM_AW),
      .DW (sdmb_pkg::DATA_W)
   ) u_mem (
      .clk   (clk),
      .en    (rd_acc || wbuf_out_valid),
      .we    (!rd_acc),
      .addr  (rd_acc ? acc_addr : wr_out.addr),
      .wdata (wr_out.data),
      .rdata (mem_rdata)
   );

endmodule

// File: rtl/sdmb_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module sdmb_fifo #(
   parameter int WIDTH = 38,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] buf_mem;
      logic [PW-1:0]               wptr;
      logic [PW-1:0]               rptr;
      logic [PW:0]                 count;
   } sdmb_fifo_st_t;

   sdmb_fifo_st_t s_q;
   sdmb_fifo_st_t s_d;

   logic push;
   logic pop;

   assign in_ready  = (s_q.count != (PW+1)'(DEPTH));
   assign out_valid = (s_q.count != '0);
   assign out_data  = s_q.buf_mem[s_q.rptr];

   always_comb begin
      s_d  = s_q;
      push = in_valid && in_ready;
      pop  = out_valid && out_ready;
      if (push) begin
         s_d.buf_mem[s_q.wptr] = in_data;
         s_d.wptr = (s_q.wptr == PW'(DEPTH-1)) ? '0 : s_q.wptr + PW'(1);
      end
      if (pop) begin
         s_d.rptr = (s_q.rptr == PW'(DEPTH-1)) ? '0 : s_q.rptr + PW'(1);
      end
      if (push && !pop) begin
         s_d.count = s_q.count + (PW+1)'(1);
      end else if (pop && !push) begin
         s_d.count = s_q.count - (PW+1)'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule

// File: rtl/sdmb_mem.sv
// single-port array with registered read data
`timescale 1ns/100ps
module sdmb_mem #(
   parameter int AW = 22,
   parameter int DW = 16
) (
   // clock
   input  wire logic          clk,
   // access port
   input  wire logic          en,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic [DW-1:0]      rdata
);
   // the array has no reset, like the cells it stands for
   logic [DW-1:0] cells [0:(1<<AW)-1];
   logic [DW-1:0] rdata_q;

   assign rdata = rdata_q;

   always_ff @(posedge clk) begin
      if (en && we) begin
         cells[addr] <= wdata;
      end
      if (en && !we) begin
         rdata_q <= cells[addr];
      end
   end

endmodule

// File: rtl/sdmb_pkg.sv
// shared constants, command codes and carrier types of the sdram burst core
package sdmb_pkg;

   // ------------------------------------------------------------------
   // array geometry
   // ------------------------------------------------------------------
   localparam int ROW_W     = 12;
   localparam int COL_W     = 8;
   localparam int BANK_W    = 2;
   localparam int NUM_BANKS = 4;
   localparam int DATA_W    = 16;
   localparam int MODE_W    = 12;
   localparam int MEM_AW    = BANK_W + ROW_W + COL_W;
   localparam int WR_ENT_W  = MEM_AW + DATA_W;
   localparam int LEN_W     = COL_W + 1;
   localparam int FIFO_DEPTH = 4;

   // ------------------------------------------------------------------
   // operating_mode_config field layout
   // ------------------------------------------------------------------
   localparam int BL_LSB  = 0;
   localparam int BT_BIT  = 3;
   localparam int CL_LSB  = 4;
   localparam int OPM_LSB = 7;
   localparam int WBM_BIT = 9;
   localparam int AP_BIT  = 10;

   localparam logic [MODE_W-1:0] MODE_RESET = 12'h000;

   localparam logic [2:0] BL_CODE_1    = 3'h0;
   localparam logic [2:0] BL_CODE_2    = 3'h1;
   localparam logic [2:0] BL_CODE_4    = 3'h2;
   localparam logic [2:0] BL_CODE_8    = 3'h3;
   localparam logic [2:0] BL_CODE_FULL = 3'h7;
   localparam logic [2:0] CL_CODE_3    = 3'h3;

   localparam logic [LEN_W-1:0] LEN_1    = 9'h001;
   localparam logic [LEN_W-1:0] LEN_2    = 9'h002;
   localparam logic [LEN_W-1:0] LEN_4    = 9'h004;
   localparam logic [LEN_W-1:0] LEN_8    = 9'h008;
   localparam logic [LEN_W-1:0] LEN_FULL = 9'h100;

   // {ras_n, cas_n, we_n} with chip select low
   typedef enum logic [2:0] {
      SDMB_CMD_LMR = 3'b000,
      SDMB_CMD_REF = 3'b001,
      SDMB_CMD_PRE = 3'b010,
      SDMB_CMD_ACT = 3'b011,
      SDMB_CMD_WR  = 3'b100,
      SDMB_CMD_RD  = 3'b101,
      SDMB_CMD_BST = 3'b110,
      SDMB_CMD_NOP = 3'b111
   } sdmb_cmd_t;

   typedef enum logic [1:0] {
      SDMB_IDLE = 2'b00,
      SDMB_RD   = 2'b01,
      SDMB_WR   = 2'b10
   } sdmb_burst_t;

   // command pins sampled together on the rising edge
   typedef struct packed {
      logic              cs_n;
      logic              ras_n;
      logic              cas_n;
      logic              we_n;
      logic              bank_select_msb;
      logic              bank_select_lsb;
      logic [ROW_W-1:0]  addr;
      logic              dqm;
   } sdmb_pins_t;

   typedef struct packed {
      logic [MEM_AW-1:0] addr;
      logic [DATA_W-1:0] data;
   } sdmb_wr_ent_t;

endpackage

// File: testbench/sdmb_core_asserts.sv
// concurrent checks on the ports of the sdram burst core
`timescale 1ns/100ps
module sdmb_core_chk #(
   parameter int WBUF_DEPTH = sdmb_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic                           clk,
   input wire logic                           rst_n,
   // pins
   input wire sdmb_pkg::sdmb_pins_t           pins,
   input wire logic [sdmb_pkg::DATA_W-1:0]    dq_in,
   input wire logic [sdmb_pkg::DATA_W-1:0]    dq_out,
   input wire logic                           dq_oe_n,
   // status
   input wire logic                           wr_buf_ready,
   input wire logic [sdmb_pkg::NUM_BANKS-1:0] bank_open
);
   // -----------------------------------------------------------------
   // command decode and shadow of the mode register
   // -----------------------------------------------------------------
   logic [sdmb_pkg::MODE_W-1:0] mode_q;
   logic [2:0]                  cmd;
   logic [1:0]                  bsel;
   logic                        rd, wr, act, pre, bst, lmr, quiet, lat3, bl1, bl2;

   assign cmd   = {pins.ras_n, pins.cas_n, pins.we_n};
   assign bsel  = {pins.bank_select_msb, pins.bank_select_lsb};
   assign rd    = !pins.cs_n && cmd == sdmb_pkg::SDMB_CMD_RD;
   assign wr    = !pins.cs_n && cmd == sdmb_pkg::SDMB_CMD_WR;
   assign act   = !pins.cs_n && cmd == sdmb_pkg::SDMB_CMD_ACT;
   assign pre   = !pins.cs_n && cmd == sdmb_pkg::SDMB_CMD_PRE;
   assign bst   = !pins.cs_n && cmd == sdmb_pkg::SDMB_CMD_BST;
   assign lmr   = !pins.cs_n && cmd == sdmb_pkg::SDMB_CMD_LMR;
   assign quiet = !(rd || wr || bst);
   assign lat3  = mode_q[sdmb_pkg::CL_LSB +: 3] == sdmb_pkg::CL_CODE_3;
   assign bl1   = mode_q[2:0] == sdmb_pkg::BL_CODE_1;
   assign bl2   = mode_q[2:0] == sdmb_pkg::BL_CODE_2;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= sdmb_pkg::MODE_RESET;
      end else if (lmr) begin
         mode_q <= pins.addr;
      end
   end

   // -----------------------------------------------------------------
   // properties
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_rd_len1;
      rd && bl1 && !lat3 ##1 quiet;
   endsequence
   sequence s_rd_len2;
      rd && bl2 && !lat3 ##1 quiet [*2];
   endsequence

   AST_RD_LAT2: assert property (rd && !lat3 |-> ##2 !dq_oe_n)
      else $error("read data not driven two cycles after read");
   AST_RD_LAT3: assert property (rd && lat3 |-> ##3 !dq_oe_n)
      else $error("read data not driven three cycles after read");
   AST_LEN1_BEATS: assert property (s_rd_len1 |-> ##1 !dq_oe_n ##1 dq_oe_n)
      else $error("single read did not give exactly one beat");
   AST_LEN2_BEATS: assert property (s_rd_len2 |-> ##1 !dq_oe_n ##1 dq_oe_n)
      else $error("read of two did not give exactly two beats");
   AST_ACT_OPEN: assert property (act |=> bank_open[$past(bsel)])
      else $error("active did not open the selected bank");
   AST_PRE_ALL: assert property (pre && pins.addr[10] |=> bank_open == 4'h0)
      else $error("precharge all left a bank open");
   AST_PRE_ONE: assert property (pre && !pins.addr[10] |=> !bank_open[$past(bsel)])
      else $error("precharge did not close the selected bank");
   AST_AP_CLOSE: assert property (rd && bl1 && pins.addr[10] |=> !bank_open[$past(bsel)])
      else $error("auto precharge did not close the bank");
   AST_BST_QUIET: assert property (bst ##1 !rd [*4] |=> dq_oe_n)
      else $error("data still driven after burst terminate");
endmodule

bind sdmb_core sdmb_core_chk #(.WBUF_DEPTH(WBUF_DEPTH)) sdmb_core_chk_i (
   .clk(clk), .rst_n(rst_n), .pins(pins), .dq_in(dq_in), .dq_out(dq_out),
   .dq_oe_n(dq_oe_n), .wr_buf_ready(wr_buf_ready), .bank_open(bank_open));

// File: testbench/sdmb_ctrl_model.sv
// controller model driving commands and write data into the sdram core
`timescale 1ns/100ps
module sdmb_ctrl_model (
   // clock
   input  wire logic                   clk,
   // pins towards the core
   output sdmb_pkg::sdmb_pins_t        pins,
   output logic [sdmb_pkg::DATA_W-1:0] dq_in
);
   // 100us of inhibit at 25 ns per cycle
   localparam int PWR_WAIT = 4000;

   initial begin
      pins  = '1;
      dq_in = 16'h0000;
   end

   // one command per cycle, launched just after the edge; msb of d says
   // the data is driven, otherwise the released bus toggles every cycle
   task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
                      input logic dqm = 1'b0, input logic [16:0] d = 17'h00000);
      @(posedge clk);
      pins  <= {1'b0, c, b, a, dqm};
      dq_in <= d[16] ? d[15:0] : ~dq_in;
   endtask

   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk);
         pins.cs_n <= 1'b1;
         dq_in     <= ~dq_in;
      end
   endtask

   task automatic init();
      idle(PWR_WAIT);
      cmd(sdmb_pkg::SDMB_CMD_PRE, 2'h0, 12'h400);
      idle(2);
      repeat (2) begin
         cmd(sdmb_pkg::SDMB_CMD_REF, 2'h0, 12'h000);
         idle(8);
      end
   endtask

   // banks are closed before every mode load, and the load is left to settle
   task automatic set_mode(input logic [11:0] m);
      cmd(sdmb_pkg::SDMB_CMD_PRE, 2'h0, 12'h400);
      idle(2);
      cmd(sdmb_pkg::SDMB_CMD_LMR, 2'h0, m);
      idle(2);
   endtask
endmodule

// File: testbench/sdram_init_mode_burst_tb.sv
// self-checking bench for the sdram bank, mode and burst core
`timescale 1ns/100ps
module sdram_init_mode_burst_tb;
   // -----------------------------------------------------------------
   // signals and instances
   // -----------------------------------------------------------------
   localparam int CYC_MAX = 8000;
   logic                           clk;
   logic                           rst_n;
   sdmb_pkg::sdmb_pins_t           pins;
   logic [sdmb_pkg::DATA_W-1:0]    dq_in;
   logic [sdmb_pkg::DATA_W-1:0]    dq_out;
   logic                           dq_oe_n;
   logic                           wr_buf_ready;
   logic [sdmb_pkg::NUM_BANKS-1:0] bank_open;
   logic [15:0]                    sh [4][256];
   logic [15:0]                    beats [$];
   int                             n_fail;
   int                             compares;
   int                             cyc;

   sdmb_ctrl_model sdmb_ctrl_model_i (.clk(clk), .pins(pins), .dq_in(dq_in));
   sdmb_core sdmb_core_i (.clk(clk), .rst_n(rst_n), .pins(pins), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe_n(dq_oe_n), .wr_buf_ready(wr_buf_ready), .bank_open(bank_open));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (dq_oe_n === 1'b0) begin
         beats.push_back(dq_out);
      end
      cyc++;
      if (cyc == CYC_MAX) begin
         n_fail++;
         report_and_stop();
      end
   end

   // -----------------------------------------------------------------
   // access tasks
   // -----------------------------------------------------------------
   task automatic report_and_stop();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic nop(input int n);
      sdmb_ctrl_model_i.idle(n);
   endtask

   task automatic sm(input logic [2:0] bl, input logic bt, input logic [2:0] cl, input logic wbm);
      sdmb_ctrl_model_i.set_mode({2'h0, wbm, 2'h0, cl, bt, bl});
   endtask

   task automatic rd(input logic [1:0] b, input logic [11:0] a);
      sdmb_ctrl_model_i.cmd(sdmb_pkg::SDMB_CMD_RD, b, a);
   endtask

   task automatic act(input logic [1:0] b, input logic [11:0] row);
      sdmb_ctrl_model_i.cmd(sdmb_pkg::SDMB_CMD_ACT, b, row);
      sdmb_ctrl_model_i.idle(2);
   endtask

   // waits up to 40 cycles for buffer space, then issues the write even if none is free
   task automatic wr(input logic [1:0] b, input logic [7:0] c, input logic [15:0] d,
                     input logic dqm);
      int w;
      w = 0;
      while (wr_buf_ready !== 1'b1 && w < 40) begin
         @(posedge clk);
         w++;
      end
      sdmb_ctrl_model_i.cmd(sdmb_pkg::SDMB_CMD_WR, b, {4'h0, c}, dqm, {1'b1, d});
      if (!dqm) begin
         sh[b][c] = d;
      end
   endtask

   task automatic chk_beats(input logic [1:0] b, input logic [7:0] s, input int n, input int len,
                            input logic il);
      logic [7:0] m;
      logic [7:0] c;
      m = 8'(len - 1);
      chk("beat count", 16'(n), 16'(beats.size()));
      for (int k = 0; k < n && k < beats.size(); k++) begin
         c = (s & ~m) | ((il ? s ^ 8'(k) : s + 8'(k)) & m);
         chk("read beat", sh[b][c], beats[k]);
      end
   endtask

   task automatic rd_chk(input logic [1:0] b, input logic [7:0] s, input int len, input logic il,
                         input logic ap);
      beats.delete();
      rd(b, {1'b0, ap, 2'h0, s});
      nop(len + 6);
      chk_beats(b, s, len, len, il);
   endtask

   // -----------------------------------------------------------------
   // test sequence
   // -----------------------------------------------------------------
   initial begin
      logic [7:0] col;
      rst_n = 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk("idle output enable", 16'h0001, {15'h0, dq_oe_n});
      chk("write buffer ready", 16'h0001, {15'h0, wr_buf_ready});
      sdmb_ctrl_model_i.init();
      sm(3'h0, 1'b0, 3'h2, 1'b0);
      act(2'h1, 12'h005);
      act(2'h2, 12'h009);
      chk("banks open", 16'h0006, {12'h0, bank_open});
      for (int i = 0; i < 24; i++) begin
         col = 8'(i < 16 ? i : i + 232);
         for (int b = 1; b < 3; b++) begin
            wr(2'(b), col, {4'ha, 2'h0, 2'(b), col}, 1'b0);
         end
      end
      wr(2'h1, 8'h03, 16'h5555, 1'b1);
      nop(8);
      for (int i = 0; i < 8; i++) begin
         sm(3'(i >> 1), i[0], 3'h2 + 3'(i[2] ^ i[0]), 1'b0);
         act(2'h1, 12'h005);
         rd_chk(2'h1, 8'h03, 1 << (i >> 1), i[0], 1'b0);
         rd_chk(2'h1, 8'h0d, 1 << (i >> 1), i[0], 1'b0);
      end
      sm(3'h7, 1'b0, 3'h3, 1'b0);
      act(2'h1, 12'h005);
      beats.delete();
      rd(2'h1, 12'h0fa);
      nop(9);
      sdmb_ctrl_model_i.cmd(sdmb_pkg::SDMB_CMD_BST, 2'h0, 12'h000);
      nop(8);
      chk_beats(2'h1, 8'hfa, 10, 256, 1'b0);
      sm(3'h1, 1'b0, 3'h2, 1'b0);
      act(2'h1, 12'h005);
      beats.delete();
      rd(2'h1, 12'h004);
      rd(2'h1, 12'h009);
      nop(8);
      chk("beat count", 16'h0003, 16'(beats.size()));
      chk("first beat", sh[1][4], beats[0]);
      chk("second burst", sh[1][9], beats[1]);
      chk("second burst wrap", sh[1][8], beats[2]);
      sm(3'h3, 1'b0, 3'h2, 1'b0);
      act(2'h1, 12'h005);
      act(2'h2, 12'h009);
      beats.delete();
      rd(2'h1, 12'h000);
      sdmb_ctrl_model_i.cmd(sdmb_pkg::SDMB_CMD_PRE, 2'h2, 12'h000);
      nop(10);
      chk_beats(2'h1, 8'h00, 8, 8, 1'b0);
      chk("banks open", 16'h0002, {12'h0, bank_open});
      sm(3'h0, 1'b0, 3'h2, 1'b0);
      act(2'h1, 12'h005);
      rd_chk(2'h1, 8'h05, 1, 1'b0, 1'b1);
      chk("auto precharge", 16'h0000, {12'h0, bank_open});
      sm(3'h2, 1'b0, 3'h2, 1'b1);
      act(2'h1, 12'h005);
      wr(2'h1, 8'h06, 16'h1234, 1'b0);
      nop(8);
      rd_chk(2'h1, 8'h04, 4, 1'b0, 1'b0);
      report_and_stop();
   end
endmodule
